//--- logic/strap_image_and_address_select.sv
// Strap decode, image select, slave address and filter zero registers
`timescale 1ns/1ps
module strap_image_and_address_select (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// Strap resistor decoder output
	input  wire logic [3:0]              strapAddressImagePin,
	// Non-volatile store status
	input  wire logic                    multiImageFile,
	input  wire logic [3:0]              lastProgrammedSlot,
	input  wire logic                    crcDone,
	input  wire logic                    crcOk,
	// Register access from the serial interface
	input  wire sias_pkg::sias_reg_req_t regReq,
	output logic [15:0]                  regRdata_r,
	output logic                         regAck_r,
	// Results
	output logic [6:0]                   slaveAddr_r,
	output logic                         addrValid_r,
	output sias_pkg::sias_image_sel_t    imageSel_r,
	output logic [5:0]                   imageLocation_r,
	output logic                         regulatorEnable_r,
	output logic                         loadFault_r,
	output logic [14:0]                  loopFilterZeroSetting_r
);
	localparam int NZ = sias_pkg::FZ_SETTINGS;
	localparam int ZW = sias_pkg::FZ_W;

	if (NZ * ZW != $bits(loopFilterZeroSetting_r)) begin : g_badFz
		$error("filter zero settings do not fill the output");
	end

	logic [15:0] baseAddr_r;
	logic [15:0] offsetCtrl_r;
	logic [15:0] fzB_r;
	logic [15:0] fzA_r;
	logic [15:0] imageCfg_r;
	logic [3:0]  strapCode;
	logic        strapDone;
	sias_pkg::sias_state_t state_r;
	sias_pkg::sias_state_t state_nxt;

	sias_strap_sampler #(.CODE_W(4)) sias_strap_sampler_i (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.strapRaw   (strapAddressImagePin),
		.strapCode_r(strapCode),
		.strapDone_r(strapDone)
	);

	function automatic logic [ZW-1:0] fzField(input logic [15:0] r, input int idx);
		fzField = r[idx*sias_pkg::FZ_STRIDE +: ZW];
	endfunction

	// Register decode
	wire hitBase = regReq.addr == sias_pkg::OFS_BASE_ADDR;
	wire hitCtrl = regReq.addr == sias_pkg::OFS_OFFSET_CTRL;
	wire hitFzB  = regReq.addr == sias_pkg::OFS_FZ_B;
	wire hitFzA  = regReq.addr == sias_pkg::OFS_FZ_A;
	wire hitImg  = regReq.addr == sias_pkg::OFS_IMAGE_CFG;
	wire [15:0] rdMux = hitBase ? baseAddr_r : hitCtrl ? offsetCtrl_r :
		hitFzB ? fzB_r : hitFzA ? fzA_r : hitImg ? imageCfg_r : 16'h0000;

	// Address formation
	wire       inhibit  = offsetCtrl_r[sias_pkg::INHIBIT_BIT];
	wire [6:0] baseAddr = baseAddr_r[sias_pkg::ADDR_LSB +: sias_pkg::ADDR_W];
	wire [6:0] sumAddr  = 7'(baseAddr + {3'h0, strapCode});
	wire       codeOver = strapCode > sias_pkg::MAX_IMAGE_CODE;
	wire       offsetOk = !multiImageFile || !codeOver;
	wire [6:0] addrNxt  = inhibit ? baseAddr : sumAddr;
	wire       validNxt = strapDone && (inhibit || offsetOk);

	// Image selection
	wire [3:0] imgCount  = imageCfg_r[sias_pkg::COUNT_LSB +: sias_pkg::COUNT_W];
	wire [5:0] imgStart  = imageCfg_r[sias_pkg::START_LSB +: sias_pkg::START_W];
	wire       inCount   = strapCode < imgCount;
	wire       multiOk   = !codeOver && inCount;
	wire [3:0] slotNxt   = multiImageFile ? strapCode : lastProgrammedSlot;
	wire       slotOk    = multiImageFile ? multiOk : (lastProgrammedSlot < sias_pkg::TOTAL_IMAGES);
	wire [5:0] locNxt    = multiImageFile ? 6'(imgStart + {2'h0, strapCode}) : {2'h0, slotNxt};

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sias_pkg::LOAD_IDLE:  if (strapDone) state_nxt = sias_pkg::LOAD_CHECK;
			sias_pkg::LOAD_CHECK: if (crcDone) state_nxt = (crcOk && slotOk) ?
				sias_pkg::LOAD_RUN : sias_pkg::LOAD_FAIL;
			sias_pkg::LOAD_RUN:   state_nxt = sias_pkg::LOAD_RUN;
			sias_pkg::LOAD_FAIL:  state_nxt = sias_pkg::LOAD_FAIL;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			baseAddr_r   <= sias_pkg::RESET_BASE;
			offsetCtrl_r <= sias_pkg::RESET_CTRL;
			fzB_r        <= sias_pkg::RESET_FZ;
			fzA_r        <= sias_pkg::RESET_FZ;
			imageCfg_r   <= sias_pkg::RESET_IMGCFG;
		end else if (regReq.wrEn) begin
			if (hitBase) baseAddr_r <= regReq.wdata;
			if (hitCtrl) offsetCtrl_r <= regReq.wdata;
			if (hitFzB) fzB_r <= regReq.wdata;
			if (hitFzA) fzA_r <= regReq.wdata;
			if (hitImg) imageCfg_r <= regReq.wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			regRdata_r <= 16'h0000;
			regAck_r   <= 1'b0;
		end else begin
			regAck_r   <= regReq.wrEn || regReq.rdEn;
			regRdata_r <= regReq.rdEn ? rdMux : 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			slaveAddr_r <= 7'h00;
			addrValid_r <= 1'b0;
		end else begin
			slaveAddr_r <= addrNxt;
			addrValid_r <= validNxt;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r           <= sias_pkg::LOAD_IDLE;
			imageSel_r        <= '0;
			imageLocation_r   <= 6'h00;
			regulatorEnable_r <= 1'b0;
			loadFault_r       <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Resolve the image as the check ends, so start and count set meanwhile apply
			if (state_r == sias_pkg::LOAD_CHECK && crcDone) begin
				imageSel_r      <= '{multiImageFile, slotNxt, slotOk};
				imageLocation_r <= locNxt;
			end
			regulatorEnable_r <= state_nxt == sias_pkg::LOAD_RUN;
			loadFault_r       <= state_nxt == sias_pkg::LOAD_FAIL;
		end
	end

	// Filter zero capacitor selections, setting 0 in the upper field of 0x64
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			loopFilterZeroSetting_r <= 15'h0000;
		end else begin
			loopFilterZeroSetting_r[0 +: ZW] <= fzField(fzA_r, sias_pkg::FZ0_LSB / sias_pkg::FZ_STRIDE);
			for (int i = 1; i < NZ; i++) begin
				loopFilterZeroSetting_r[i*ZW +: ZW] <= fzField(fzB_r, i - 1);
			end
		end
	end

	a_inhibit_addr: assert property (@(posedge clock) disable iff (sys_rst)
		inhibit |=> slaveAddr_r == $past(baseAddr))
		else $error("inhibited address differs from base");
	a_offset_addr: assert property (@(posedge clock) disable iff (sys_rst)
		!inhibit |=> slaveAddr_r == 7'($past(baseAddr) + {3'h0, $past(strapCode)}))
		else $error("offset address wrong");
	a_high_unreach: assert property (@(posedge clock) disable iff (sys_rst)
		(multiImageFile && !inhibit && strapCode > sias_pkg::MAX_IMAGE_CODE) |=> !addrValid_r)
		else $error("offset above twelve reachable in multi-image");
	a_single_any: assert property (@(posedge clock) disable iff (sys_rst)
		(!multiImageFile && strapDone) |=> addrValid_r)
		else $error("single-image offset refused");
	a_valid_strap: assert property (@(posedge clock) disable iff (sys_rst)
		!strapDone |=> !addrValid_r)
		else $error("address valid before strap capture");
	a_crc_block: assert property (@(posedge clock) disable iff (sys_rst)
		(state_r == sias_pkg::LOAD_CHECK && crcDone && !crcOk) |=> !regulatorEnable_r [*2])
		else $error("regulator started after crc failure");
	a_multi_slot: assert property (@(posedge clock) disable iff (sys_rst)
		(state_r == sias_pkg::LOAD_CHECK && crcDone && multiImageFile) |=>
		imageSel_r.imageSlot == $past(strapCode) && imageSel_r.imageValid ==
		($past(strapCode) <= sias_pkg::MAX_IMAGE_CODE && $past(strapCode) < $past(imgCount)))
		else $error("multi-image slot wrong");
	a_multi_loc: assert property (@(posedge clock) disable iff (sys_rst)
		(state_r == sias_pkg::LOAD_CHECK && crcDone && multiImageFile) |=>
		imageLocation_r == 6'($past(imgStart) + {2'h0, $past(strapCode)}))
		else $error("multi-image location wrong");
	a_single_slot: assert property (@(posedge clock) disable iff (sys_rst)
		(state_r == sias_pkg::LOAD_CHECK && crcDone && !multiImageFile) |=>
		imageSel_r.imageSlot == $past(lastProgrammedSlot))
		else $error("single-image slot wrong");
	a_fz_zero: assert property (@(posedge clock) disable iff (sys_rst)
		1'b1 |=> loopFilterZeroSetting_r[0 +: ZW] == $past(fzA_r[sias_pkg::FZ0_LSB +: ZW])
		&& loopFilterZeroSetting_r[(NZ-1)*ZW +: ZW]
		== $past(fzB_r[(NZ-2)*sias_pkg::FZ_STRIDE +: ZW]))
		else $error("filter zero mapping wrong");
	a_run_hold: assert property (@(posedge clock) disable iff (sys_rst)
		regulatorEnable_r |=> regulatorEnable_r)
		else $error("load state left run");
	a_fault_hold: assert property (@(posedge clock) disable iff (sys_rst)
		loadFault_r |=> loadFault_r)
		else $error("load fault cleared without reset");
	a_run_fault_excl: assert property (@(posedge clock) disable iff (sys_rst)
		regulatorEnable_r |-> !loadFault_r)
		else $error("regulator enabled while load fault set");
	a_ack_follows: assert property (@(posedge clock) disable iff (sys_rst)
		regAck_r == $past(regReq.wrEn || regReq.rdEn))
		else $error("register acknowledge out of step");

	c_run:     cover property (@(posedge clock) disable iff (sys_rst) $rose(regulatorEnable_r));
	c_fail:    cover property (@(posedge clock) disable iff (sys_rst) $rose(loadFault_r));
	c_inhibit: cover property (@(posedge clock) disable iff (sys_rst) inhibit && addrValid_r);
	c_multi:   cover property (@(posedge clock) disable iff (sys_rst)
		imageSel_r.multiImage && imageSel_r.imageValid);
	c_single:  cover property (@(posedge clock) disable iff (sys_rst)
		!imageSel_r.multiImage && imageSel_r.imageValid);
endmodule

//--- logic/sias_pkg.sv
// Package for the strap image and address select block
package sias_pkg;
	localparam logic [7:0] OFS_BASE_ADDR   = 8'h40;
	localparam logic [7:0] OFS_OFFSET_CTRL = 8'h42;
	localparam logic [7:0] OFS_FZ_B        = 8'h62;
	localparam logic [7:0] OFS_FZ_A        = 8'h64;
	localparam logic [7:0] OFS_IMAGE_CFG   = 8'h00;
	localparam int INHIBIT_BIT    = 6;
	localparam int ADDR_LSB       = 0;
	localparam int ADDR_W         = 7;
	localparam int START_LSB      = 8;
	localparam int START_W        = 6;
	localparam int COUNT_LSB      = 0;
	localparam int COUNT_W        = 4;
	localparam int FZ_W           = 3;
	localparam int FZ0_LSB        = 12;
	localparam int FZ_STRIDE      = 4;
	localparam int FZ_SETTINGS    = 5;
	localparam logic [3:0] MAX_STRAP_CODE = 4'hf;
	localparam logic [3:0] MAX_IMAGE_CODE = 4'hc;
	localparam logic [3:0] USER_IMAGES    = 4'hd;
	localparam logic [3:0] TOTAL_IMAGES   = 4'he;
	localparam logic [15:0] RESET_BASE    = 16'h0000;
	localparam logic [15:0] RESET_CTRL    = 16'h0000;
	localparam logic [15:0] RESET_FZ      = 16'h0000;
	localparam logic [15:0] RESET_IMGCFG  = 16'h0001;

	typedef enum logic [1:0] {
		LOAD_IDLE,
		LOAD_CHECK,
		LOAD_RUN,
		LOAD_FAIL
	} sias_state_t;

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [15:0] wdata;
	} sias_reg_req_t;

	typedef struct packed {
		logic       multiImage;
		logic [3:0] imageSlot;
		logic       imageValid;
	} sias_image_sel_t;
endpackage

//--- logic/sias_strap_sampler.sv
// Three-flop strap synchroniser with a one-shot capture after reset
`timescale 1ns/1ps
module sias_strap_sampler #(
	parameter int CODE_W = 4
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Strap code from the resistor decoder
	input  wire logic [CODE_W-1:0] strapRaw,
	// Captured code
	output logic [CODE_W-1:0]      strapCode_r,
	output logic                   strapDone_r
);
	if (CODE_W < 1) begin : g_badWidth
		$error("CODE_W must be positive");
	end

	logic [CODE_W-1:0] syncA_r;
	logic [CODE_W-1:0] syncB_r;
	logic [CODE_W-1:0] syncC_r;
	wire               stable = (syncB_r == syncC_r);

	always_ff @(posedge clock) begin
		syncA_r <= strapRaw;
		syncB_r <= syncA_r;
		syncC_r <= syncB_r;
	end

	// Capture once after reset and hold until the next sys_rst
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strapDone_r <= 1'b0;
			strapCode_r <= '0;
		end else if (!strapDone_r && stable) begin
			strapDone_r <= 1'b1;
			strapCode_r <= syncC_r;
		end
	end

	a_strap_held: assert property (@(posedge clock) disable iff (sys_rst)
		strapDone_r |=> strapDone_r && $stable(strapCode_r))
		else $error("strap code changed after capture");
endmodule

//--- verification/sias_far_model.sv
// Far-side model: strap resistor level and configuration store status
`timescale 1ns/1ps
module sias_far_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Scenario controls
	input  wire logic [3:0] strapSel,
	input  wire logic       crcGood,
	// Toward the block
	output logic [3:0]      strapPin,
	output logic            crcDone,
	output logic            crcOk
);
	logic [3:0] waitCnt_r;
	assign strapPin = strapSel;
	// Check ends late and stays as a level; result toggles until it is valid
	assign crcDone = (waitCnt_r == 4'hf);
	assign crcOk   = crcDone ? crcGood : waitCnt_r[0];
	always_ff @(posedge clock) begin
		if (sys_rst)
			waitCnt_r <= 4'h0;
		else if (!crcDone)
			waitCnt_r <= waitCnt_r + 4'h1;
	end
endmodule

//--- verification/strap_image_and_address_select_test.sv
// Self-checking bench for the strap image and address select block
`timescale 1ns/1ps
module strap_image_and_address_select_test;
	typedef struct packed {
		logic       multi;
		logic [3:0] strap;
		logic [3:0] slot;
		logic       inh;
		logic [6:0] base;
		logic [6:0] addr;
		logic       aOk;
		logic       img;
		logic [5:0] loc;
		logic       en;
	} sias_row_t;
	sias_row_t rows [7] = '{
		'{1'b0, 4'hf, 4'h5, 1'b0, 7'h10, 7'h1f, 1'b1, 1'b1, 6'h05, 1'b1},
		'{1'b1, 4'h0, 4'h9, 1'b0, 7'h20, 7'h20, 1'b1, 1'b1, 6'h02, 1'b1},
		'{1'b1, 4'hc, 4'h9, 1'b0, 7'h20, 7'h2c, 1'b1, 1'b1, 6'h0e, 1'b1},
		'{1'b1, 4'hd, 4'h9, 1'b0, 7'h20, 7'h00, 1'b0, 1'b0, 6'h00, 1'b0},
		'{1'b1, 4'he, 4'h9, 1'b1, 7'h55, 7'h55, 1'b1, 1'b0, 6'h00, 1'b0},
		'{1'b0, 4'h3, 4'hd, 1'b1, 7'h7f, 7'h7f, 1'b1, 1'b1, 6'h0d, 1'b1},
		'{1'b0, 4'h1, 4'he, 1'b0, 7'h7f, 7'h00, 1'b1, 1'b0, 6'h00, 1'b0}
	};
	logic clock = 1'b0;
	logic sys_rst, crcGood, multiImageFile, crcDone, crcOk;
	logic regAck_r, addrValid_r, regulatorEnable_r, loadFault_r;
	logic [3:0] strapSel, strapPin, lastProgrammedSlot;
	logic [15:0] regRdata_r;
	logic [6:0] slaveAddr_r;
	logic [5:0] imageLocation_r;
	logic [14:0] loopFilterZeroSetting_r;
	sias_pkg::sias_reg_req_t regReq;
	sias_pkg::sias_image_sel_t imageSel_r;
	int miscompares = 0;
	int checksDone = 0;
	int cycles = 0;

	always #50 clock = ~clock;

	sias_far_model sias_far_model_i (.clock(clock), .sys_rst(sys_rst), .strapSel(strapSel),
		.crcGood(crcGood), .strapPin(strapPin), .crcDone(crcDone), .crcOk(crcOk));
	strap_image_and_address_select strap_image_and_address_select_i (.clock(clock),
		.sys_rst(sys_rst), .strapAddressImagePin(strapPin), .multiImageFile(multiImageFile),
		.lastProgrammedSlot(lastProgrammedSlot), .crcDone(crcDone), .crcOk(crcOk),
		.regReq(regReq), .regRdata_r(regRdata_r), .regAck_r(regAck_r),
		.slaveAddr_r(slaveAddr_r), .addrValid_r(addrValid_r), .imageSel_r(imageSel_r),
		.imageLocation_r(imageLocation_r), .regulatorEnable_r(regulatorEnable_r),
		.loadFault_r(loadFault_r), .loopFilterZeroSetting_r(loopFilterZeroSetting_r));

	task automatic testDone;
		$display("Comparisons %0d, mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checksDone++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] exp);
		@(posedge clock);
		#1 regReq = '{wr, !wr, a, d};
		@(posedge clock);
		#1 regReq = '0;
		chk("ack", 16'h0001, {15'h0, regAck_r});
		if (!wr)
			chk("rdata", exp, regRdata_r);
	endtask

	task automatic start(input sias_row_t r, input logic good, input logic cfg);
		int n;
		@(posedge clock);
		#1 sys_rst = 1'b1;
		multiImageFile = r.multi;
		lastProgrammedSlot = r.slot;
		strapSel = r.strap;
		crcGood = good;
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b0;
		if (cfg) begin
			bus(1'b1, sias_pkg::OFS_IMAGE_CFG, 16'h020d, 16'h0);
			bus(1'b1, sias_pkg::OFS_BASE_ADDR, {9'h0, r.base}, 16'h0);
			bus(1'b1, sias_pkg::OFS_OFFSET_CTRL, {9'h0, r.inh, 6'h0}, 16'h0);
		end
		n = 0;
		while (regulatorEnable_r !== 1'b1 && loadFault_r !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1 n++;
		end
	endtask

	task automatic verify(input sias_row_t r);
		chk("addrValid", {15'h0, r.aOk}, {15'h0, addrValid_r});
		if (r.aOk)
			chk("slaveAddr", {9'h0, r.addr}, {9'h0, slaveAddr_r});
		chk("imageValid", {15'h0, r.img}, {15'h0, imageSel_r.imageValid});
		chk("multiImage", {15'h0, r.multi}, {15'h0, imageSel_r.multiImage});
		if (r.img)
			chk("slot", {12'h0, r.multi ? r.strap : r.slot}, {12'h0, imageSel_r.imageSlot});
		if (r.img)
			chk("location", {10'h0, r.loc}, {10'h0, imageLocation_r});
		chk("enable", {15'h0, r.en}, {15'h0, regulatorEnable_r});
		chk("fault", {15'h0, !r.en}, {15'h0, loadFault_r});
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			testDone();
		end
	end

	initial begin
		sys_rst = 1'b1;
		strapSel = 4'h0;
		crcGood = 1'b1;
		multiImageFile = 1'b0;
		lastProgrammedSlot = 4'h0;
		regReq = '0;
		for (int i = 0; i < 7; i++) begin
			start(rows[i], 1'b1, 1'b1);
			verify(rows[i]);
		end
		// Reset values, unmapped place, filter zero routing
		start(rows[0], 1'b1, 1'b0);
		bus(1'b0, sias_pkg::OFS_IMAGE_CFG, 16'h0, sias_pkg::RESET_IMGCFG);
		bus(1'b0, sias_pkg::OFS_BASE_ADDR, 16'h0, sias_pkg::RESET_BASE);
		bus(1'b0, sias_pkg::OFS_OFFSET_CTRL, 16'h0, sias_pkg::RESET_CTRL);
		bus(1'b0, sias_pkg::OFS_FZ_B, 16'h0, sias_pkg::RESET_FZ);
		bus(1'b0, sias_pkg::OFS_FZ_A, 16'h0, sias_pkg::RESET_FZ);
		bus(1'b1, 8'h10, 16'hffff, 16'h0);
		bus(1'b0, 8'h10, 16'h0, 16'h0);
		bus(1'b1, sias_pkg::OFS_FZ_A, 16'h5000, 16'h0);
		bus(1'b1, sias_pkg::OFS_FZ_B, 16'h4321, 16'h0);
		bus(1'b0, sias_pkg::OFS_FZ_B, 16'h0, 16'h4321);
		chk("filterZero", 16'h468d, {1'b0, loopFilterZeroSetting_r});
		// Strap moves after capture: address must not follow
		chk("slaveAddr", 16'h000f, {9'h0, slaveAddr_r});
		strapSel = 4'h2;
		repeat (8) @(posedge clock);
		#1 chk("slaveAddr", 16'h000f, {9'h0, slaveAddr_r});
		bus(1'b1, sias_pkg::OFS_OFFSET_CTRL, 16'h0040, 16'h0);
		bus(1'b1, sias_pkg::OFS_BASE_ADDR, 16'h0033, 16'h0);
		bus(1'b0, sias_pkg::OFS_BASE_ADDR, 16'h0, 16'h0033);
		chk("slaveAddr", 16'h0033, {9'h0, slaveAddr_r});
		// Failed check holds the regulator off
		start(rows[1], 1'b0, 1'b1);
		chk("enable", 16'h0000, {15'h0, regulatorEnable_r});
		chk("fault", 16'h0001, {15'h0, loadFault_r});
		testDone();
	end
endmodule
